/* core/lhi_pkg.sv */
// lan controller host interface constants
package lhi_pkg;
   localparam int SYS_CLK_HZ = 100_000_000;
   // request sizing
   localparam logic [15:0] MAX_REQ_B = 16'h0080;
   localparam logic [15:0] PAGE_B    = 16'h1000;
   localparam int          ALN_W     = 7;
   localparam int          PAGE_W    = 12;
   // sideband link rates
   localparam int SML_100K_HZ = 100_000;
   localparam int SML_400K_HZ = 400_000;
   localparam int SML_1M_HZ   = 1_000_000;
   localparam logic [9:0] SML_DIV_100K = 10'(SYS_CLK_HZ / SML_100K_HZ);
   localparam logic [9:0] SML_DIV_400K = 10'(SYS_CLK_HZ / SML_400K_HZ);
   localparam logic [9:0] SML_DIV_1M   = 10'(SYS_CLK_HZ / SML_1M_HZ);
   localparam logic [1:0] SML_SEL_100K = 2'h0;
   localparam logic [1:0] SML_SEL_400K = 2'h1;
   localparam logic [1:0] SML_SEL_1M   = 2'h2;
   // receive buffer sizes
   localparam logic [14:0] RXB_MIN_B  = 15'h0100;
   localparam logic [14:0] RXB_MAX_B  = 15'h4000;
   localparam logic [2:0]  RXB_MAX_CD = 3'h6;
   // packet buffer split, kb
   localparam logic [5:0] PKT_BUF_KB = 6'h20;
   localparam logic [5:0] PKT_MIN_KB = 6'h01;
   // largest jumbo frame
   localparam logic [13:0] JUMBO_MAX_B = 14'h233a;
   localparam logic [47:0] BCAST_ADDR  = 48'hffff_ffff_ffff;
   localparam int          MC_BIT      = 40;
   // phy on level
   localparam logic PHY_ON = 1'b1;

   typedef enum logic [1:0] {SYS_S0, SYS_S0IX, SYS_SX, SYS_DSX} lhi_sys_t;
   typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} lhi_spd_t;
   typedef enum logic [1:0] {CS_SC, CS_UR, CS_CRS, CS_CA} lhi_cs_t;
   typedef enum logic [1:0] {RT_MEM, RT_IO, RT_CFG, RT_MSG} lhi_rt_t;
endpackage

/* core/lhi_top.sv */
// lan controller host interface
//
// Functional notes
// - memory requests split so none crosses a 4 KB page.
// - requests carry at most 128 bytes; reads stay 128-byte aligned.
// - config requests get retry status until nvm load done.
// - model violations dropped; non-posted get completer abort.
// - unsupported requests dropped, non-posted answered unsupported, error flag set.
// - phy port preset from nvm, no detect, half-rate transmitter.
// - sideband clock is 100 kHz, 400 kHz or 1 MHz only.
// - full duplex at every speed; half duplex only at 10/100.
// - gigabit only in S0; S0ix and Sx use sideband.
// - traffic, wake and manageability interfaces follow system state.
// - wake activity raises host wake outside S0.
// - only config accesses taken outside D0.
// - sleep control held at its strap value in deep sleep; phy powered unless low power requested while sleep control high.
// - receive buffer size spans 256 bytes to 16 KB.
// - rx/tx fifo split in 1 KB steps inside 32 KB.
// - frames up to 9018 bytes accepted.
// - sw reset clears all but configuration space and sleep control.
// - dma addresses are 64 bits.
// - rss picks one of two receive queues.
// - unicast, multicast hash, broadcast and promiscuous filters.
// - sleep control low if disabled, high if enabled.
// - phy power control low only while sleep control high.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lhi_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   cnt;
   logic          push;
   logic          pop;

   assign in_ready  = cnt != (AW+1)'(D);
   assign out_valid = cnt != '0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
         end
         cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // lhi_fifo

////////////////////////////////////////////////////////////////////////////////
module lhi_top import lhi_pkg::*; #(
   parameter int FIFO_D = 8
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        sw_reset,
   input  wire logic        nvm_load_done,
   input  wire logic [1:0]  nvm_port_sel,
   input  wire logic        lan_enable_strap,
   // incoming requests
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire lhi_rt_t     req_kind,
   input  wire logic        req_posted,
   input  wire logic        req_bad_model,
   input  wire logic        req_unsupported,
   input  wire logic [7:0]  req_tag,
   output logic             cpl_valid,
   input  wire logic        cpl_ready,
   output lhi_cs_t          cpl_status,
   output logic [7:0]       cpl_tag,
   // config state
   input  wire logic        cfg_pm_wr,
   input  wire logic        cfg_pm_d3,
   input  wire logic        urd_clear,
   output logic             unsupported_request_seen_flag,
   output logic             pm_in_d3,
   // dma commands and pieces
   input  wire logic        dma_valid,
   output logic             dma_ready,
   input  wire logic [63:0] dma_addr,
   input  wire logic [15:0] dma_len,
   input  wire logic        dma_write,
   output logic             mreq_valid,
   input  wire logic        mreq_ready,
   output logic [63:0]      mreq_addr,
   output logic [15:0]      mreq_len,
   output logic             mreq_write,
   // link and mac configuration
   input  wire lhi_sys_t    sys_state,
   input  wire lhi_spd_t    mac_speed,
   input  wire logic        half_duplex_req,
   input  wire logic [1:0]  sml_rate_sel,
   output logic [9:0]       sml_clk_div,
   output logic [1:0]       phy_port,
   output logic             phy_port_half_rate,
   output logic             full_duplex,
   output logic             csma_cd_en,
   output logic             gig_allowed,
   output logic             data_link_active,
   output logic             sideband_active,
   output logic             wake_pin_active,
   // wake and power pins
   input  wire logic        phy_wake_input_n,
   input  wire logic        mac_wake_event,
   input  wire logic        phy_low_power_req,
   output logic             host_wake,
   output logic             lan_sleep_control_n,
   output logic             phy_power_control,
   // buffers, frames and filters
   input  wire logic [2:0]  rx_buf_code,
   output logic [14:0]      rx_buf_bytes,
   input  wire logic [5:0]  rx_alloc_kb,
   output logic [5:0]       rx_fifo_kb,
   output logic [5:0]       tx_fifo_kb,
   input  wire logic [13:0] frame_len,
   output logic             frame_len_ok,
   input  wire logic        rss_en,
   input  wire logic [31:0] rss_hash,
   output logic             rx_queue,
   input  wire logic [47:0] frame_dst,
   input  wire logic [47:0] uc_addr,
   input  wire logic [63:0] mc_hash_tbl,
   input  wire logic        bcast_en,
   input  wire logic        promisc_en,
   output logic             frame_accept
);
   logic    lrst;
   logic    nvm_done;
   logic    take;
   lhi_cs_t next_cs;
   logic    is_ur;

   assign lrst = !rstn || sw_reset;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (lrst);

   ///////////////////////////////////////////////////////////////////////////
   // config state, kept over sw reset
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         nvm_done <= 1'b0;
         phy_port <= '0;
      end else if (nvm_load_done && !nvm_done) begin
         nvm_done <= 1'b1;
         phy_port <= nvm_port_sel;
      end
   end

   assign phy_port_half_rate = nvm_done;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pm_in_d3 <= 1'b0;
      end else if (cfg_pm_wr) begin
         pm_in_d3 <= cfg_pm_d3;
      end
   end

   // set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         unsupported_request_seen_flag <= 1'b0;
      end else if (take && is_ur) begin
         unsupported_request_seen_flag <= 1'b1;
      end else if (urd_clear) begin
         unsupported_request_seen_flag <= 1'b0;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // requests and completions
   assign req_ready = !cpl_valid;
   assign take      = req_valid && req_ready;

   always_comb begin
      next_cs = CS_SC;
      if (req_kind == RT_CFG && !nvm_done) begin
         next_cs = CS_CRS;
      end else if (req_kind != RT_CFG && pm_in_d3) begin
         next_cs = CS_UR;
      end else if (req_unsupported) begin
         next_cs = CS_UR;
      end else if (req_bad_model) begin
         next_cs = CS_CA;
      end
   end

   assign is_ur = next_cs == CS_UR;

   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         cpl_valid  <= 1'b0;
         cpl_status <= CS_SC;
         cpl_tag    <= '0;
      end else if (take) begin
         cpl_valid  <= !req_posted;
         cpl_status <= next_cs;
         cpl_tag    <= req_tag;
      end else if (cpl_ready) begin
         cpl_valid <= 1'b0;
      end
   end

   crs_a: assert property (take && req_kind == RT_CFG && !nvm_done && !req_posted
      |=> cpl_valid && cpl_status == CS_CRS) else $error("no retry status");
   abort_a: assert property (take && !req_posted && next_cs != CS_UR && req_bad_model
      && req_kind != RT_CFG |=> cpl_status == CS_CA) else $error("no abort");
   ur_flag_a: assert property (take && req_unsupported && nvm_done
      |=> unsupported_request_seen_flag) else $error("flag not set");
   posted_a: assert property (take && req_posted |=> !cpl_valid)
      else $error("posted completion");
   d3_a: assert property (take && pm_in_d3 && req_kind == RT_MEM
      && !req_posted |=> cpl_status == CS_UR) else $error("taken in d3");
   crs_c: cover property (take && next_cs == CS_CRS);
   abort_c: cover property (take && next_cs == CS_CA && req_posted);

   ///////////////////////////////////////////////////////////////////////////
   // dma splitting
   logic [63:0] cur_addr;
   logic [15:0] rem;
   logic        cur_wr;
   logic        busy;
   logic [15:0] piece;
   logic        fin_ready;
   logic        push;

   function automatic logic [15:0] piece_len(logic [63:0] a, logic [15:0] r,
                                             logic wr);
      logic [15:0] lim;
      logic [15:0] to_pg;
      to_pg = PAGE_B - {4'h0, a[PAGE_W-1:0]};
      lim   = wr ? MAX_REQ_B : MAX_REQ_B - {9'h0, a[ALN_W-1:0]};
      if (to_pg < lim) begin
         lim = to_pg;
      end
      return (r < lim) ? r : lim;
   endfunction

   assign piece     = piece_len(cur_addr, rem, cur_wr);
   assign dma_ready = !busy;
   assign push      = busy && fin_ready;

   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         busy     <= 1'b0;
         cur_addr <= '0;
         rem      <= '0;
         cur_wr   <= 1'b0;
      end else if (dma_valid && !busy) begin
         busy     <= dma_len != '0;
         cur_addr <= dma_addr;
         rem      <= dma_len;
         cur_wr   <= dma_write;
      end else if (push) begin
         cur_addr <= cur_addr + {48'h0, piece};
         rem      <= rem - piece;
         busy     <= rem != piece;
      end
   end

   lhi_fifo #(.W(81), .D(FIFO_D)) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (lrst),
      .in_valid  (busy),
      .in_ready  (fin_ready),
      .in_data   ({cur_wr, piece, cur_addr}),
      .out_valid (mreq_valid),
      .out_ready (mreq_ready),
      .out_data  ({mreq_write, mreq_len, mreq_addr})
   );

   size_a: assert property (push |-> piece <= MAX_REQ_B && piece != '0)
      else $error("request too long");
   page_a: assert property (push |-> {4'h0, cur_addr[PAGE_W-1:0]} + piece <= PAGE_B)
      else $error("page crossed");
   align_a: assert property (push && !cur_wr
      |-> {9'h0, cur_addr[ALN_W-1:0]} + piece <= MAX_REQ_B)
      else $error("read unaligned");
   split_c: cover property (push ##1 push && $past(cur_addr[PAGE_W-1:0]) != '0);

   ///////////////////////////////////////////////////////////////////////////
   // link modes per system state
   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         sml_clk_div <= SML_DIV_100K;
      end else begin
         case (sml_rate_sel)
            SML_SEL_100K: sml_clk_div <= SML_DIV_100K;
            SML_SEL_400K: sml_clk_div <= SML_DIV_400K;
            SML_SEL_1M:   sml_clk_div <= SML_DIV_1M;
            default:      sml_clk_div <= sml_clk_div;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         gig_allowed      <= 1'b0;
         data_link_active <= 1'b0;
         sideband_active  <= 1'b0;
         wake_pin_active  <= 1'b0;
         full_duplex      <= 1'b1;
         csma_cd_en       <= 1'b0;
      end else begin
         gig_allowed      <= sys_state == SYS_S0;
         data_link_active <= sys_state == SYS_S0;
         sideband_active  <= sys_state == SYS_S0IX || sys_state == SYS_SX;
         wake_pin_active  <= sys_state != SYS_S0;
         full_duplex      <= !half_duplex_req || mac_speed == SPD_1000;
         csma_cd_en       <= half_duplex_req && mac_speed != SPD_1000;
      end
   end

   half_a: assert property (csma_cd_en |-> $past(mac_speed) != SPD_1000 && !full_duplex)
      else $error("half duplex at gigabit");
   gig_a: assert property (gig_allowed |-> !sideband_active && $past(sys_state) == SYS_S0)
      else $error("gigabit outside s0");

   ///////////////////////////////////////////////////////////////////////////
   // wake and power pins
   logic s1;
   logic s2;
   logic s3;
   logic pin_wake;
   logic strap_done;

   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         s1       <= 1'b1;
         s2       <= 1'b1;
         s3       <= 1'b1;
         pin_wake <= 1'b0;
      end else begin
         s1 <= phy_wake_input_n;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            pin_wake <= !s3;
         end
      end
   end

   // set wins; cleared once back in S0
   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         host_wake <= 1'b0;
      end else if (sys_state != SYS_S0 && (mac_wake_event || pin_wake)) begin
         host_wake <= 1'b1;
      end else if (sys_state == SYS_S0) begin
         host_wake <= 1'b0;
      end
   end

   // strap taken once after reset
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         strap_done          <= 1'b0;
         lan_sleep_control_n <= 1'b0;
      end else if (!strap_done) begin
         strap_done          <= 1'b1;
         lan_sleep_control_n <= lan_enable_strap;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         phy_power_control <= PHY_ON;
      end else begin
         phy_power_control <= !(phy_low_power_req && lan_sleep_control_n);
      end
   end

   wake_a: assert property (sys_state == SYS_DSX && mac_wake_event |=> host_wake)
      else $error("wake lost");
   phy_pc_a: assert property (!phy_power_control |-> $past(lan_sleep_control_n))
      else $error("phy off while sleep asserted");
   slp_a: assert property (strap_done && sys_state == SYS_DSX |-> $stable(lan_sleep_control_n))
      else $error("sleep control moved");
   wake_c: cover property (sys_state == SYS_SX && pin_wake ##1 host_wake);

   ///////////////////////////////////////////////////////////////////////////
   // buffers and filtering
   logic [5:0] rx_k;
   logic       mc_hit;

   assign rx_k   = (rx_alloc_kb < PKT_MIN_KB) ? PKT_MIN_KB :
                   (rx_alloc_kb >= PKT_BUF_KB) ? PKT_BUF_KB - PKT_MIN_KB : rx_alloc_kb;
   assign mc_hit = frame_dst[MC_BIT] && mc_hash_tbl[frame_dst[5:0]];

   always_ff @(posedge clk_sys) begin
      if (lrst) begin
         rx_buf_bytes <= RXB_MIN_B;
         rx_fifo_kb   <= PKT_BUF_KB >> 1;
         tx_fifo_kb   <= PKT_BUF_KB >> 1;
         frame_len_ok <= 1'b0;
         rx_queue     <= 1'b0;
         frame_accept <= 1'b0;
      end else begin
         rx_buf_bytes <= (rx_buf_code > RXB_MAX_CD) ? RXB_MAX_B
                         : RXB_MIN_B << rx_buf_code;
         rx_fifo_kb   <= rx_k;
         tx_fifo_kb   <= PKT_BUF_KB - rx_k;
         frame_len_ok <= frame_len <= JUMBO_MAX_B;
         rx_queue     <= rss_en && rss_hash[0];
         frame_accept <= promisc_en || frame_dst == uc_addr || mc_hit
                         || (bcast_en && frame_dst == BCAST_ADDR);
      end
   end

   split_kb_a: assert property (rx_fifo_kb + tx_fifo_kb == PKT_BUF_KB)
      else $error("fifo split wrong");
   jumbo_a: assert property (frame_len == JUMBO_MAX_B |=> frame_len_ok)
      else $error("jumbo refused");
endmodule // lhi_top

/* tb/lhi_mreq_sink.sv */
// host model draining split requests
`timescale 1ns/1ps

module lhi_mreq_sink (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        stall,
   input  wire logic        slow,
   input  wire logic        mreq_valid,
   output logic             mreq_ready,
   input  wire logic [63:0] mreq_addr,
   input  wire logic [15:0] mreq_len,
   input  wire logic        mreq_write
);
   logic        phase;
   logic [63:0] got_addr [32];
   logic [15:0] got_len  [32];
   logic        got_wr   [32];
   int          got_cnt;

   // slow: every other cycle
   assign mreq_ready = !stall && (phase || !slow);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         phase   <= 1'b0;
         got_cnt <= 0;
      end else begin
         phase <= !phase;
         if (mreq_valid && mreq_ready && got_cnt < 32) begin
            got_addr[got_cnt] <= mreq_addr;
            got_len[got_cnt]  <= mreq_len;
            got_wr[got_cnt]   <= mreq_write;
            got_cnt           <= got_cnt + 1;
         end
      end
   end
endmodule // lhi_mreq_sink

/* tb/tb_top.sv */
// bench for the lan controller host interface
`timescale 1ns/1ps

module tb_top import lhi_pkg::*;;
   typedef struct packed {
      lhi_sys_t st; lhi_spd_t spd; logic hd; logic [1:0] sel; logic [2:0] code;
      logic [5:0] alloc; logic [13:0] flen; logic [47:0] dst; logic bc; logic pr;
      logic [31:0] hash; logic [9:0] div; logic [14:0] bytes; logic [5:0] rxkb;
      logic fd; logic lok; logic acc;
   } lhi_tb_row_t;

   logic        clk_sys, rstn, sw_reset, nvm_load_done, lan_enable_strap, req_valid;
   logic        req_posted, req_bad_model, req_unsupported, cpl_ready, cfg_pm_wr;
   logic        cfg_pm_d3, urd_clear, dma_valid, dma_write, half_duplex_req, stall, slow;
   logic        phy_wake_input_n, mac_wake_event, phy_low_power_req, rss_en, bcast_en;
   logic        promisc_en, req_ready, cpl_valid, unsupported_request_seen_flag;
   logic        pm_in_d3, dma_ready, mreq_valid, mreq_ready, mreq_write, full_duplex;
   logic        phy_port_half_rate, csma_cd_en, gig_allowed, data_link_active;
   logic        sideband_active, wake_pin_active, host_wake, lan_sleep_control_n;
   logic        phy_power_control, frame_len_ok, rx_queue, frame_accept;
   logic [1:0]  nvm_port_sel, sml_rate_sel, phy_port;
   logic [7:0]  req_tag, cpl_tag;
   logic [63:0] dma_addr, mc_hash_tbl, mreq_addr;
   logic [15:0] dma_len, mreq_len;
   logic [2:0]  rx_buf_code;
   logic [5:0]  rx_alloc_kb, rx_fifo_kb, tx_fifo_kb;
   logic [13:0] frame_len;
   logic [31:0] rss_hash;
   logic [47:0] frame_dst, uc_addr;
   logic [9:0]  sml_clk_div;
   logic [14:0] rx_buf_bytes;
   lhi_rt_t     req_kind;
   lhi_cs_t     cpl_status;
   lhi_sys_t    sys_state;
   lhi_spd_t    mac_speed;
   lhi_tb_row_t rows [7];
   logic [63:0] exp_a [$];
   logic [15:0] exp_l [$];
   logic        exp_w [$];
   int          error_cnt, comparisons, cycles, i;

   lhi_top #(.FIFO_D(8)) u_dut (.*);
   lhi_mreq_sink u_sink (.*);

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, logic [63:0] exp, logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic do_req(input lhi_rt_t k, logic p, logic bad, logic uns, logic [7:0] t,
                         lhi_cs_t exp);
      req_kind = k;
      {req_posted, req_bad_model, req_unsupported, req_tag} = {p, bad, uns, t};
      req_valid = 1'b1;
      tick(1);
      req_valid = 1'b0;
      chk("cpl_valid", 64'(!p), 64'(cpl_valid));
      if (!p) begin
         chk("cpl_status", 64'(exp), 64'(cpl_status));
         chk("cpl_tag", 64'(t), 64'(cpl_tag));
         cpl_ready = 1'b1;
         tick(1);
         cpl_ready = 1'b0;
         chk("cpl_clr", 64'h0, 64'(cpl_valid));
      end
   endtask

   task automatic do_dma(input logic [63:0] a, logic [15:0] len, logic w);
      logic [63:0] pa;
      logic [15:0] rem, pc;
      int          n;
      pa = a;
      rem = len;
      while (rem != 16'h0000) begin
         pc = w ? 16'(4096 - pa[11:0]) : 16'(128 - pa[6:0]);
         if (pc > MAX_REQ_B) pc = MAX_REQ_B;
         if (pc > rem) pc = rem;
         exp_a.push_back(pa);
         exp_l.push_back(pc);
         exp_w.push_back(w);
         pa = pa + 64'(pc);
         rem = rem - pc;
      end
      {dma_addr, dma_len, dma_write} = {a, len, w};
      dma_valid = 1'b1;
      n = 0;
      while (!dma_ready && n < 300) begin
         tick(1);
         n++;
      end
      tick(1);
      dma_valid = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk_sys, rstn, sw_reset, nvm_load_done, req_valid, req_posted} = 6'h00;
      {req_bad_model, req_unsupported, cpl_ready, cfg_pm_wr, cfg_pm_d3} = 5'h00;
      {urd_clear, dma_valid, dma_write, half_duplex_req, mac_wake_event} = 5'h00;
      {phy_low_power_req, bcast_en, promisc_en, slow} = 4'h0;
      {lan_enable_strap, phy_wake_input_n, rss_en, stall} = 4'hf;
      {nvm_port_sel, sml_rate_sel, req_tag, rx_buf_code, rx_alloc_kb} = 21'h0;
      {dma_addr, dma_len, frame_len, rss_hash, frame_dst} = 174'h0;
      req_kind = RT_MEM;
      sys_state = SYS_S0;
      mac_speed = SPD_1000;
      uc_addr = 48'h0012_3456_789a;
      mc_hash_tbl = 64'h0000_0000_0000_0020;
      rows = '{
         '{SYS_S0, SPD_1000, 1'b1, 2'h0, 3'h0, 6'h00, 14'h233a, 48'h0012_3456_789a, 1'b0,
           1'b0, 32'h1, 10'h3e8, 15'h0100, 6'h01, 1'b1, 1'b1, 1'b1},
         '{SYS_S0, SPD_100, 1'b1, 2'h1, 3'h6, 6'h10, 14'h233b, 48'hffff_ffff_ffff, 1'b1,
           1'b0, 32'h2, 10'h0fa, 15'h4000, 6'h10, 1'b0, 1'b0, 1'b1},
         '{SYS_S0IX, SPD_10, 1'b0, 2'h2, 3'h7, 6'h1f, 14'h0040, 48'h0100_0000_0005, 1'b0,
           1'b0, 32'h3, 10'h064, 15'h4000, 6'h1f, 1'b1, 1'b1, 1'b1},
         '{SYS_SX, SPD_10, 1'b1, 2'h3, 3'h3, 6'h28, 14'h0000, 48'h0100_0000_0006, 1'b0,
           1'b0, 32'h0, 10'h064, 15'h0800, 6'h1f, 1'b0, 1'b1, 1'b0},
         '{SYS_DSX, SPD_100, 1'b0, 2'h0, 3'h1, 6'h01, 14'h3fff, 48'hffff_ffff_ffff, 1'b0,
           1'b0, 32'h5, 10'h3e8, 15'h0200, 6'h01, 1'b1, 1'b0, 1'b0},
         '{SYS_S0, SPD_1000, 1'b0, 2'h1, 3'h5, 6'h08, 14'h05ee, 48'h0012_3456_789b, 1'b0,
           1'b1, 32'h4, 10'h0fa, 15'h2000, 6'h08, 1'b1, 1'b1, 1'b1},
         '{SYS_S0, SPD_100, 1'b0, 2'h2, 3'h2, 6'h20, 14'h0001, 48'h0012_3456_789b, 1'b0,
           1'b0, 32'h7, 10'h064, 15'h0400, 6'h1f, 1'b1, 1'b1, 1'b0}};
      tick(20);
      chk("req_ready_rst", 64'h1, 64'(req_ready));
      chk("dma_ready_rst", 64'h1, 64'(dma_ready));
      chk("mreq_valid_rst", 64'h0, 64'(mreq_valid));
      chk("sleep_ctl_rst", 64'h0, 64'(lan_sleep_control_n));
      chk("phy_pwr_rst", 64'h1, 64'(phy_power_control));
      chk("fifo_rst", 64'h410, {rx_fifo_kb, tx_fifo_kb});
      rstn = 1'b1;
      tick(2);
      chk("sleep_ctl_on", 64'h1, 64'(lan_sleep_control_n));
      chk("half_rate_pre", 64'h0, 64'(phy_port_half_rate));
      for (i = 0; i < 7; i++) begin
         sys_state = rows[i].st;
         mac_speed = rows[i].spd;
         {half_duplex_req, sml_rate_sel} = {rows[i].hd, rows[i].sel};
         {rx_buf_code, rx_alloc_kb, frame_len, frame_dst} = rows[i][138:68];
         {bcast_en, promisc_en, rss_hash} = {rows[i].bc, rows[i].pr, rows[i].hash};
         tick(2);
         chk("sml_clk_div", 64'(rows[i].div), 64'(sml_clk_div));
         chk("rx_buf_bytes", 64'(rows[i].bytes), 64'(rx_buf_bytes));
         chk("fifo_kb", {rows[i].rxkb, 6'(32 - rows[i].rxkb)}, {rx_fifo_kb, tx_fifo_kb});
         chk("duplex", {rows[i].fd, !rows[i].fd}, {full_duplex, csma_cd_en});
         chk("gig_link", {2{sys_state == SYS_S0}}, {gig_allowed, data_link_active});
         chk("wake_pin", 64'(sys_state != SYS_S0), 64'(wake_pin_active));
         chk("sideband", 64'(sys_state inside {SYS_S0IX, SYS_SX}), 64'(sideband_active));
         chk("frame_len_ok", 64'(rows[i].lok), 64'(frame_len_ok));
         chk("frame_accept", 64'(rows[i].acc), 64'(frame_accept));
         chk("rx_queue", 64'(rows[i].hash[0]), 64'(rx_queue));
      end
      sys_state = SYS_S0;
      do_req(RT_CFG, 1'b0, 1'b0, 1'b0, 8'h11, CS_CRS);
      nvm_port_sel = 2'h2;
      nvm_load_done = 1'b1;
      tick(2);
      chk("phy_port", 64'h5, {phy_port, phy_port_half_rate});
      do_req(RT_CFG, 1'b0, 1'b0, 1'b0, 8'h21, CS_SC);
      do_req(RT_IO, 1'b0, 1'b1, 1'b0, 8'h23, CS_CA);
      do_req(RT_MSG, 1'b1, 1'b1, 1'b0, 8'h24, CS_SC);
      chk("flag_ca", 64'h0, 64'(unsupported_request_seen_flag));
      do_req(RT_MEM, 1'b0, 1'b1, 1'b1, 8'h25, CS_UR);
      chk("flag_ur", 64'h1, 64'(unsupported_request_seen_flag));
      urd_clear = 1'b1;
      tick(1);
      urd_clear = 1'b0;
      tick(1);
      chk("flag_clr", 64'h0, 64'(unsupported_request_seen_flag));
      do_req(RT_MEM, 1'b1, 1'b0, 1'b1, 8'h26, CS_SC);
      chk("flag_posted", 64'h1, 64'(unsupported_request_seen_flag));
      {cfg_pm_d3, cfg_pm_wr} = 2'h3;
      tick(1);
      cfg_pm_wr = 1'b0;
      tick(1);
      chk("pm_in_d3", 64'h1, 64'(pm_in_d3));
      do_req(RT_MEM, 1'b0, 1'b0, 1'b0, 8'h31, CS_UR);
      do_req(RT_CFG, 1'b0, 1'b0, 1'b0, 8'h32, CS_SC);
      {cfg_pm_d3, cfg_pm_wr} = 2'h1;
      tick(1);
      cfg_pm_wr = 1'b0;
      tick(1);
      do_req(RT_MEM, 1'b0, 1'b0, 1'b0, 8'h33, CS_SC);
      // stalled sink fills the buffer
      do_dma(64'h0000_0000_0000_0fc0, 16'h0100, 1'b0);
      do_dma(64'h0000_0001_ffff_ffe0, 16'h0200, 1'b1);
      do_dma(64'h0000_0000_0000_2000, 16'h0080, 1'b0);
      tick(10);
      chk("full_stall", 64'h1, {dma_ready, mreq_valid});
      chk("none_drained", 64'h0, 64'(u_sink.got_cnt));
      {stall, slow} = 2'h1;
      i = 0;
      while (u_sink.got_cnt < exp_a.size() && i < 500) begin
         tick(1);
         i++;
      end
      tick(2);
      chk("drained", 64'(exp_a.size()), 64'(u_sink.got_cnt));
      chk("empty", 64'h0, 64'(mreq_valid));
      for (i = 0; i < exp_a.size(); i++) begin
         chk("piece_addr", exp_a[i], u_sink.got_addr[i]);
         chk("piece_len", 64'(exp_l[i]), 64'(u_sink.got_len[i]));
         chk("piece_wr", 64'(exp_w[i]), 64'(u_sink.got_wr[i]));
      end
      sys_state = SYS_SX;
      tick(2);
      chk("no_wake", 64'h0, 64'(host_wake));
      phy_wake_input_n = 1'b0;
      tick(6);
      chk("pin_wake", 64'h1, 64'(host_wake));
      phy_wake_input_n = 1'b1;
      sys_state = SYS_S0;
      tick(2);
      chk("wake_clr", 64'h0, 64'(host_wake));
      {sys_state, mac_wake_event} = {SYS_DSX, 1'b1};
      tick(2);
      chk("mac_wake", 64'h3, {host_wake, lan_sleep_control_n});
      {mac_wake_event, phy_low_power_req} = 2'h1;
      tick(2);
      chk("phy_low", 64'h0, 64'(phy_power_control));
      sw_reset = 1'b1;
      tick(2);
      chk("sw_rst_div", 64'h3e8, 64'(sml_clk_div));
      chk("sw_keep", 64'hb, {phy_port, unsupported_request_seen_flag, lan_sleep_control_n});
      {sw_reset, rstn, lan_enable_strap} = 3'h0;
      tick(2);
      rstn = 1'b1;
      tick(3);
      chk("disabled", 64'h1, {lan_sleep_control_n, phy_power_control});
      give_verdict();
   end
endmodule // tb_top
